// ### src/dsd_pkg.sv
// Constants, layouts and decode helpers for the data space decoder.
package dsd_pkg;
  localparam int DSD_RAM_DEPTH = 256;
  localparam int DSD_REC_W = 32;
  localparam int DSD_CNT_W = 6;
  localparam logic [5:0] DSD_REC_FULL = 6'h20;
  localparam logic [5:0] DSD_REC_EMPTY = 6'h00;
  localparam logic [7:0] DSD_LOW_TOP = 8'h7F;
  localparam logic [7:0] DSD_BIT_BASE = 8'h20;
  localparam logic [7:0] DSD_SP_ADDR = 8'h81;
  localparam logic [7:0] DSD_PAGE_ADDR = 8'h84;
  localparam logic [7:0] DSD_NEXT_ADDR = 8'h85;
  localparam logic [7:0] DSD_LAST_ADDR = 8'h86;
  localparam logic [7:0] DSD_PGCTL_ADDR = 8'h96;
  localparam logic [7:0] DSD_PSW_ADDR = 8'hD0;
  localparam logic [7:0] DSD_PAGE_F = 8'h0F;
  localparam logic [7:0] DSD_PAGE_3 = 8'h03;
  localparam logic [7:0] DSD_SP_RST = 8'h07;
  localparam logic [7:0] DSD_PAGE_RST = 8'h00;
  localparam logic [7:0] DSD_PGCTL_RST = 8'h01;
  localparam logic [7:0] DSD_PGCTL_MASK = 8'h01;
  localparam logic [7:0] DSD_PSW_RST = 8'h00;
  localparam logic [7:0] DSD_ONE = 8'h01;
  localparam int DSD_PGEN_BIT = 0;
  localparam int DSD_BANK_LO = 3;
  localparam int DSD_BANK_HI = 4;
  localparam logic [3:0] DSD_PORT_LAST = 4'hB;
  localparam logic [2:0] DSD_BIT_ROW = 3'h0;

  // Registers decoded on every page, whatever the page select holds.
  function automatic logic dsd_all_pages(input logic [7:0] a);
    return (a[3:0] == 4'h0 && a[7:4] <= DSD_PORT_LAST)
      || a == DSD_SP_ADDR || a == DSD_PAGE_ADDR
      || a == DSD_NEXT_ADDR || a == DSD_LAST_ADDR
      || a == DSD_PSW_ADDR;
  endfunction

  function automatic logic dsd_page_impl(input logic [7:0] p);
    return p <= DSD_PAGE_3 || p == DSD_PAGE_F;
  endfunction

  function automatic logic [7:0] dsd_set_bit(input logic [7:0] v,
    input logic [2:0] pos, input logic b);
    logic [7:0] r;
    r = v;
    r[pos] = b;
    return r;
  endfunction
endpackage

// ### src/dsd_rec_if.sv
// Link between the decoder and its stack record shift register.
`timescale 1ns/100ps
interface dsd_rec_if;
  logic push;
  logic pop;
  logic bit_in;
  logic overflow;
  logic underflow;
  logic [5:0] depth;
  modport core (output push, output pop, output bit_in,
    input overflow, input underflow, input depth);
  modport rec (input push, input pop, input bit_in,
    output overflow, output underflow, output depth);
endinterface

// ### src/dsd_stack_record.sv
// Stack record shift register with overflow and underflow detection.
`timescale 1ns/100ps
module dsd_stack_record
  import dsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  dsd_rec_if.rec rif
);
  typedef struct packed {
    logic [DSD_REC_W-1:0] bits;
    logic [DSD_CNT_W-1:0] depth;
    logic ovf;
    logic udf;
  } dsd_rec_t;

  dsd_rec_t st_r;
  dsd_rec_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ovf = 1'b0;
    st_nxt.udf = 1'b0;
    if (rif.push)
    begin
      st_nxt.bits = {st_r.bits[DSD_REC_W-2:0], rif.bit_in};
      // The oldest bit is lost on overflow; depth saturates at full.
      if (st_r.depth == DSD_REC_FULL)
        st_nxt.ovf = 1'b1;
      else
        st_nxt.depth = st_r.depth + 6'h01;
    end
    else if (rif.pop)
    begin
      st_nxt.bits = {1'b0, st_r.bits[DSD_REC_W-1:1]};
      if (st_r.depth == DSD_REC_EMPTY)
        st_nxt.udf = 1'b1;
      else
        st_nxt.depth = st_r.depth - 6'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rif.overflow = st_r.ovf;
  assign rif.underflow = st_r.udf;
  assign rif.depth = st_r.depth;

  rec_overflow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rif.push && st_r.depth == DSD_REC_FULL
    |=> st_r.ovf && st_r.depth == DSD_REC_FULL)
    else $error("Record overflow not flagged.");
  rec_underflow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rif.push && rif.pop && st_r.depth == DSD_REC_EMPTY
    |=> st_r.udf && !st_r.ovf)
    else $error("Record underflow not flagged.");
  rec_depth_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rif.push && st_r.depth != DSD_REC_FULL
    |=> st_r.depth == $past(st_r.depth) + 6'h01
      && st_r.bits[0] == $past(rif.bit_in))
    else $error("Record push did not shift in.");
endmodule

// ### src/dsd_data_space.sv
// Internal data space decoder with stack, bit map and page stack.
`timescale 1ns/100ps
module dsd_data_space
  import dsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_indirect,
  input wire logic acc_bit,
  input wire logic acc_ri_sel,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic stk_push,
  input wire logic stk_pop,
  input wire logic stk_call_ret,
  input wire logic [7:0] stk_wdata,
  input wire logic int_enter,
  input wire logic [7:0] int_page,
  input wire logic int_return,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic ext_req,
  output logic ext_write,
  output logic ext_bit,
  output logic [2:0] ext_bit_pos,
  output logic [7:0] ext_addr,
  output logic [7:0] ext_wdata,
  output logic ext_all_pages,
  output logic ext_page_ok,
  output logic [7:0] active_page,
  output logic auto_paging,
  output logic rec_overflow,
  output logic rec_underflow
);
  typedef struct packed {
    logic [DSD_RAM_DEPTH-1:0][7:0] ram;
    logic [7:0] sp;
    logic [7:0] program_status_word;
    logic [7:0] page;
    logic [7:0] next;
    logic [7:0] last;
    logic [7:0] pgctl;
    logic [7:0] rdata;
    logic rvalid;
    logic ext_req;
    logic ext_wr;
    logic ext_bit;
    logic [2:0] ext_pos;
    logic [7:0] ext_addr;
    logic [7:0] ext_wdata;
    logic ext_all;
    logic ext_ok;
  } dsd_state_t;

  dsd_state_t st_r;
  dsd_state_t st_nxt;
  dsd_rec_if rif ();

  logic [1:0] bank;
  logic [7:0] ptr;
  logic [7:0] ea;
  logic [7:0] tgt;
  logic [7:0] cur;
  logic [7:0] newv;
  logic [2:0] pos;
  logic is_sfr;
  logic hit;
  logic pgen;
  logic rec_push;
  logic rec_pop;
  logic rec_bit;

  assign pgen = st_r.pgctl[DSD_PGEN_BIT];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.ext_req = 1'b0;
    rec_push = 1'b0;
    rec_pop = 1'b0;
    rec_bit = 1'b0;
    hit = 1'b1;
    cur = 8'h00;
    bank = st_r.program_status_word[DSD_BANK_HI:DSD_BANK_LO];
    ptr = st_r.ram[{3'h0, bank, 2'h0, acc_ri_sel}];
    ea = acc_indirect ? ptr : acc_addr;
    pos = acc_addr[2:0];
    if (acc_bit)
    begin
      // Bit operands never go indirect, so the raw address is used.
      is_sfr = acc_addr[7];
      if (acc_addr[7])
        tgt = {acc_addr[7:3], DSD_BIT_ROW};
      else
        tgt = DSD_BIT_BASE | {4'h0, acc_addr[6:3]};
    end
    else
    begin
      is_sfr = !acc_indirect && ea > DSD_LOW_TOP;
      tgt = ea;
    end
    if (is_sfr)
    begin
      case (tgt)
        DSD_SP_ADDR: cur = st_r.sp;
        DSD_PSW_ADDR: cur = st_r.program_status_word;
        DSD_PAGE_ADDR: cur = st_r.page;
        DSD_NEXT_ADDR: cur = st_r.next;
        DSD_LAST_ADDR: cur = st_r.last;
        DSD_PGCTL_ADDR:
        begin
          cur = st_r.pgctl;
          hit = st_r.page == DSD_PAGE_F;
        end
        default: hit = 1'b0;
      endcase
    end
    else
      cur = st_r.ram[tgt];
    newv = acc_bit ? dsd_set_bit(cur, pos, acc_wdata[0]) : acc_wdata;

    // One operation per cycle; interrupt sequencing outranks the rest.
    if (int_enter)
    begin
      if (pgen)
      begin
        st_nxt.last = st_r.next;
        st_nxt.next = st_r.page;
        st_nxt.page = int_page;
      end
    end
    else if (int_return)
    begin
      if (pgen)
      begin
        st_nxt.page = st_r.next;
        st_nxt.next = st_r.last;
        st_nxt.last = DSD_PAGE_RST;
      end
    end
    else if (stk_push)
    begin
      st_nxt.ram[st_r.sp + DSD_ONE] = stk_wdata;
      st_nxt.sp = st_r.sp + DSD_ONE;
      rec_push = 1'b1;
      rec_bit = stk_call_ret;
    end
    else if (stk_pop)
    begin
      st_nxt.rdata = st_r.ram[st_r.sp];
      st_nxt.rvalid = 1'b1;
      st_nxt.sp = st_r.sp - DSD_ONE;
      rec_pop = 1'b1;
    end
    else if (acc_valid)
    begin
      if (is_sfr && !hit)
      begin
        // Unoccupied addresses pass out with ext_page_ok giving the page check; their
        // effect is left to the peripheral side.
        st_nxt.ext_req = 1'b1;
        st_nxt.ext_wr = acc_write;
        st_nxt.ext_bit = acc_bit;
        st_nxt.ext_pos = pos;
        st_nxt.ext_addr = tgt;
        st_nxt.ext_wdata = acc_wdata;
        st_nxt.ext_all = dsd_all_pages(tgt);
        st_nxt.ext_ok = dsd_all_pages(tgt)
          || dsd_page_impl(st_r.page);
      end
      else if (acc_write)
      begin
        if (!is_sfr)
          st_nxt.ram[tgt] = newv;
        else
        begin
          case (tgt)
            DSD_SP_ADDR:
            begin
              st_nxt.sp = newv;
              // A step of one counts as an increment or decrement.
              rec_push = newv == st_r.sp + DSD_ONE;
              rec_pop = newv == st_r.sp - DSD_ONE;
            end
            DSD_PSW_ADDR: st_nxt.program_status_word = newv;
            DSD_PAGE_ADDR: st_nxt.page = newv;
            DSD_NEXT_ADDR: st_nxt.next = newv;
            DSD_LAST_ADDR: st_nxt.last = newv;
            default: st_nxt.pgctl = newv & DSD_PGCTL_MASK;
          endcase
        end
      end
      else
      begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rdata = acc_bit ? {7'h00, cur[pos]} : cur;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.sp <= DSD_SP_RST;
      st_r.program_status_word <= DSD_PSW_RST;
      st_r.page <= DSD_PAGE_RST;
      st_r.next <= DSD_PAGE_RST;
      st_r.last <= DSD_PAGE_RST;
      st_r.pgctl <= DSD_PGCTL_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign rif.push = rec_push;
  assign rif.pop = rec_pop;
  assign rif.bit_in = rec_bit;

  dsd_stack_record u_rec (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rif(rif)
  );

  assign rd_data = st_r.rdata;
  assign rd_valid = st_r.rvalid;
  assign ext_req = st_r.ext_req;
  assign ext_write = st_r.ext_wr;
  assign ext_bit = st_r.ext_bit;
  assign ext_bit_pos = st_r.ext_pos;
  assign ext_addr = st_r.ext_addr;
  assign ext_wdata = st_r.ext_wdata;
  assign ext_all_pages = st_r.ext_all;
  assign ext_page_ok = st_r.ext_ok;
  assign active_page = st_r.page;
  assign auto_paging = st_r.pgctl[DSD_PGEN_BIT];
  assign rec_overflow = rif.overflow;
  assign rec_underflow = rif.underflow;

  default clocking dsd_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic idle_hi;
  assign idle_hi = !int_enter && !int_return && !stk_push && !stk_pop;

  sequence s_enter;
    int_enter && pgen;
  endsequence
  sequence s_return;
    !int_enter && int_return && pgen;
  endsequence

  int_push_a: assert property (s_enter |=> st_r.page == $past(int_page)
    && st_r.next == $past(st_r.page)
    && st_r.last == $past(st_r.next))
    else $error("Page stack push wrong.");
  int_pop_a: assert property (s_return |=> st_r.page == $past(st_r.next)
    && st_r.next == $past(st_r.last) && st_r.last == DSD_PAGE_RST)
    else $error("Page stack pop wrong.");
  page_trip_a: assert property (s_enter ##1 s_return
    |=> st_r.page == $past(st_r.page, 2))
    else $error("Page not restored after return.");
  auto_off_a: assert property ((int_enter || int_return) && !pgen
    |=> $stable(st_r.page) && $stable(st_r.next)
      && $stable(st_r.last))
    else $error("Page stack moved while auto paging off.");
  sw_next_a: assert property (idle_hi && acc_valid && acc_write
    && !acc_bit && !acc_indirect && acc_addr == DSD_NEXT_ADDR
    |=> st_r.next == $past(acc_wdata) && $stable(st_r.page)
      && $stable(st_r.last))
    else $error("Stack byte write disturbed others.");
  push_sp_a: assert property (!int_enter && !int_return && stk_push
    |=> st_r.sp == $past(st_r.sp) + DSD_ONE
      && st_r.ram[st_r.sp] == $past(stk_wdata))
    else $error("Push did not land above pointer.");
  upper_ram_a: assert property (idle_hi && acc_valid && acc_write
    && acc_indirect && !acc_bit && ptr > DSD_LOW_TOP
    |=> st_r.ram[$past(ptr)] == $past(acc_wdata) && !st_r.ext_req)
    else $error("Indirect upper write misrouted.");
  sfr_route_a: assert property (idle_hi && acc_valid && !acc_indirect
    && !acc_bit && acc_addr > DSD_LOW_TOP && !hit
    |=> st_r.ext_req && st_r.ext_addr == $past(acc_addr)
    ##1 !st_r.ext_req || $past(acc_valid))
    else $error("Direct upper access not sent out.");
  bit_map_a: assert property (idle_hi && acc_valid && acc_write
    && acc_bit && !acc_addr[7]
    |=> st_r.ram[DSD_BIT_BASE | {4'h0, $past(acc_addr[6:3])}]
      [$past(acc_addr[2:0])] == $past(acc_wdata[0]))
    else $error("Bit write hit wrong RAM bit.");
endmodule

// ### sim/dsd_core_model.sv
// Core-side model that issues data space, stack and interrupt requests.
`timescale 1ns/100ps
module dsd_core_model (
  input wire logic sys_clk,
  output logic acc_valid,
  output logic acc_write,
  output logic acc_indirect,
  output logic acc_bit,
  output logic acc_ri_sel,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  output logic stk_push,
  output logic stk_pop,
  output logic stk_call_ret,
  output logic [7:0] stk_wdata,
  output logic int_enter,
  output logic [7:0] int_page,
  output logic int_return
);
  initial
  begin
    {acc_valid, acc_write, acc_indirect, acc_bit, acc_ri_sel} = 5'h00;
    {acc_addr, acc_wdata, stk_wdata, int_page} = 32'h0000_0000;
    {stk_push, stk_pop, stk_call_ret, int_enter, int_return} = 5'h00;
  end

  // Released lines show the inverse, so a stale value never looks valid.
  task automatic acc(input logic w, i, b, r, input logic [7:0] a, d);
    @(negedge sys_clk);
    {acc_write, acc_indirect, acc_bit, acc_ri_sel} = {w, i, b, r};
    {acc_valid, acc_addr, acc_wdata} = {1'h1, a, d};
    @(negedge sys_clk);
    {acc_valid, acc_addr, acc_wdata} = {1'h0, ~a, ~d};
  endtask

  task automatic stk(input logic pu, po, c, input logic [7:0] d);
    @(negedge sys_clk);
    {stk_push, stk_pop, stk_call_ret, stk_wdata} = {pu, po, c, d};
    @(negedge sys_clk);
    {stk_push, stk_pop, stk_call_ret, stk_wdata} = {3'h0, ~d};
  endtask

  task automatic irq(input logic en, re, input logic [7:0] p);
    @(negedge sys_clk);
    {int_enter, int_return, int_page} = {en, re, p};
    @(negedge sys_clk);
    {int_enter, int_return, int_page} = {2'h0, ~p};
  endtask

  // Entry followed at once by return, as a source that is cleared at once.
  task automatic irq_trip(input logic [7:0] p);
    @(negedge sys_clk);
    {int_enter, int_return, int_page} = {2'h2, p};
    @(negedge sys_clk);
    {int_enter, int_return, int_page} = {2'h1, ~p};
    @(negedge sys_clk);
    {int_enter, int_return} = 2'h0;
  endtask
endmodule

// ### sim/tb_dsd_data_space.sv
// Self-checking bench for the data space decoder.
`timescale 1ns/100ps
module tb_dsd_data_space;
  logic sys_clk, rst_n, acc_valid, acc_write, acc_indirect, acc_bit;
  logic acc_ri_sel, stk_push, stk_pop, stk_call_ret, int_enter, int_return;
  logic [7:0] acc_addr, acc_wdata, stk_wdata, int_page;
  logic [7:0] rd_data, ext_addr, ext_wdata, active_page, r;
  logic rd_valid, ext_req, ext_write, ext_bit, ext_all_pages, ext_page_ok;
  logic auto_paging, rec_overflow, rec_underflow;
  logic [2:0] ext_bit_pos;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  logic [7:0] dv[4];
  int mismatches = 0;
  int num_checks = 0;
  int ovf_cnt = 0;
  int unf_cnt = 0;

  dsd_data_space u_dsd_data_space (.sys_clk, .rst_n, .acc_valid,
    .acc_write, .acc_indirect, .acc_bit, .acc_ri_sel, .acc_addr,
    .acc_wdata, .stk_push, .stk_pop, .stk_call_ret, .stk_wdata,
    .int_enter, .int_page, .int_return, .rd_data, .rd_valid, .ext_req,
    .ext_write, .ext_bit, .ext_bit_pos, .ext_addr, .ext_wdata,
    .ext_all_pages, .ext_page_ok, .active_page, .auto_paging,
    .rec_overflow, .rec_underflow);

  dsd_core_model u_dsd_core_model (.sys_clk, .acc_valid, .acc_write,
    .acc_indirect, .acc_bit, .acc_ri_sel, .acc_addr, .acc_wdata,
    .stk_push, .stk_pop, .stk_call_ret, .stk_wdata, .int_enter,
    .int_page, .int_return);

  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ac(input logic w, i, b, s, input logic [7:0] a, d);
    u_dsd_core_model.acc(w, i, b, s, a, d);
  endtask

  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    ac(1'h0, 1'h0, 1'h0, 1'h0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, d);
    ac(1'h1, 1'h0, 1'h0, 1'h0, a, d);
  endtask

  task automatic st(input logic pu, po, c, input logic [7:0] d);
    u_dsd_core_model.stk(pu, po, c, d);
  endtask

  // A forwarded access answers with a pulse; wait a bounded few cycles.
  task automatic ext_acc(input logic w, b, input logic [7:0] a, d,
    input logic ok, all);
    int i;
    ac(w, 1'h0, b, 1'h0, a, d);
    for (i = 0; i < 3 && ext_req !== 1'h1; i++)
      @(negedge sys_clk);
    chk("ext_addr", b ? {a[7:3], 3'h0} : a, ext_addr);
    chk("ext_wdata", d, ext_wdata);
    chk("ext_flags", {3'h0, w, b, 1'h1, ok, all},
      {3'h0, ext_write, ext_bit, ext_req, ext_page_ok, ext_all_pages});
    if (b)
      chk("ext_bit_pos", {5'h00, a[2:0]}, {5'h00, ext_bit_pos});
  endtask

  task automatic pirq(input logic en, re, input logic [7:0] p, e);
    u_dsd_core_model.irq(en, re, p);
    @(negedge sys_clk);
    chk("active_page", e, active_page);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(negedge sys_clk)
  begin
    if (rec_overflow === 1'h1)
      ovf_cnt++;
    if (rec_underflow === 1'h1)
      unf_cnt++;
    if (rd_valid === 1'h1)
    begin
      if (exp_q.size() == 0)
        chk("rd_valid", 8'h00, 8'h01);
      else
        chk("rd_data", exp_q.pop_front(), rd_data);
    end
  end

  initial
  begin
    #(3000 * 100);
    mismatches++;
    conclude();
  end

  initial
  begin
    seed = 32'h0000_D4C7;
    rst_n = 1'h0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'h1;
    chk("auto_paging", 8'h01, {7'h00, auto_paging});
    chk("active_page", 8'h00, active_page);
    rd(8'h81, 8'h07);
    rd(8'h85, 8'h00);
    rd(8'h86, 8'h00);
    done("reset");
    st(1'h1, 1'h0, 1'h0, 8'h5A);
    rd(8'h81, 8'h08);
    rd(8'h08, 8'h5A);
    exp_q.push_back(8'h5A);
    st(1'h0, 1'h1, 1'h0, 8'h00);
    exp_q.push_back(8'h00);
    st(1'h0, 1'h1, 1'h0, 8'h00);
    rd(8'h81, 8'h06);
    chk("underflow", 8'h01, 8'(unf_cnt));
    wr(8'h81, 8'h07);
    for (int i = 0; i < 32; i++)
    begin
      r = 8'(xs());
      if (i == 31)
        chk("overflow", 8'h00, 8'(ovf_cnt));
      st(1'h1, 1'h0, i[0], r);
    end
    rd(8'h81, 8'h27);
    rd(8'h27, r);
    chk("overflow", 8'h01, 8'(ovf_cnt));
    done("stack");
    wr(8'h30, r);
    rd(8'h30, r);
    for (int b = 0; b < 4; b++)
    begin
      dv[b] = 8'(xs());
      wr(8'hD0, 8'(b << 3));
      wr(8'(8 * b + 1), 8'(8'hA0 + b));
      ac(1'h1, 1'h1, 1'h0, 1'h1, 8'h00, dv[b]);
    end
    wr(8'hD0, 8'h00);
    for (int b = 0; b < 4; b++)
    begin
      wr(8'h00, 8'(8'hA0 + b));
      exp_q.push_back(dv[b]);
      ac(1'h0, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00);
    end
    wr(8'h00, 8'h30);
    exp_q.push_back(r);
    ac(1'h0, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00);
    ext_acc(1'h0, 1'h0, 8'hA0, 8'h00, 1'h1, 1'h1);
    ext_acc(1'h1, 1'h0, 8'hA0, dv[0], 1'h1, 1'h1);
    done("banks");
    wr(8'h22, 8'h00);
    ac(1'h1, 1'h0, 1'h1, 1'h0, 8'h13, 8'h01);
    ac(1'h1, 1'h0, 1'h1, 1'h0, 8'h7F, 8'h01);
    rd(8'h22, 8'h08);
    rd(8'h2F, 8'h80);
    exp_q.push_back(8'h01);
    ac(1'h0, 1'h0, 1'h1, 1'h0, 8'h13, 8'h00);
    ac(1'h1, 1'h0, 1'h1, 1'h0, 8'hD3, 8'h01);
    rd(8'hD0, 8'h08);
    wr(8'hD0, 8'h00);
    ext_acc(1'h1, 1'h1, 8'h9B, 8'h01, 1'h1, 1'h0);
    done("bits");
    wr(8'h84, 8'h0F);
    wr(8'h96, 8'h00);
    @(negedge sys_clk);
    chk("auto_paging", 8'h00, {7'h00, auto_paging});
    pirq(1'h1, 1'h0, 8'h02, 8'h0F);
    pirq(1'h0, 1'h1, 8'h00, 8'h0F);
    rd(8'h85, 8'h00);
    wr(8'h96, 8'hFF);
    rd(8'h96, 8'h01);
    pirq(1'h1, 1'h0, 8'h02, 8'h02);
    pirq(1'h1, 1'h0, 8'h00, 8'h00);
    rd(8'h85, 8'h02);
    rd(8'h86, 8'h0F);
    wr(8'h86, 8'h03);
    @(negedge sys_clk);
    chk("active_page", 8'h00, active_page);
    pirq(1'h0, 1'h1, 8'h00, 8'h02);
    rd(8'h85, 8'h03);
    pirq(1'h0, 1'h1, 8'h00, 8'h03);
    rd(8'h85, 8'h00);
    wr(8'h85, 8'h01);
    chk("active_page", 8'h03, active_page);
    rd(8'h85, 8'h01);
    pirq(1'h0, 1'h1, 8'h00, 8'h01);
    u_dsd_core_model.irq_trip(8'h03);
    @(negedge sys_clk);
    chk("active_page", 8'h01, active_page);
    rd(8'h85, 8'h00);
    done("paging");
    for (int k = 0; k < 8; k++)
    begin
      r = (k == 4) ? 8'h0F : ((k < 4) ? 8'(k) : 8'(xs()));
      wr(8'h84, r);
      rd(8'h84, r);
      ext_acc(1'h0, 1'h0, 8'hC1, 8'h00,
        r <= 8'h03 || r == 8'h0F, 1'h0);
      ext_acc(1'h0, 1'h0, 8'(8'h80 + 16 * (k % 4)), 8'h00, 1'h1,
        1'h1);
    end
    done("decode");
    repeat (3) @(negedge sys_clk);
    chk("queue_left", 8'h00, 8'(exp_q.size()));
    conclude();
  end
endmodule
